// File: hw/fmt_events_pkg.sv
// Constants for the formatter event, enable, stack and branch-select block.
// Assumes one 40 MHz clock and an 8-bit microcontroller register port.
package fmt_events_pkg;
   // Register offsets on the microcontroller port.
   localparam logic [7:0] EVENT_FLAGS_OFS = 8'h7D;
   localparam logic [7:0] EVENT_ENABLE_OFS = 8'h7E;
   localparam logic [7:0] RING_STACK_OFS = 8'h7F;
   localparam logic [7:0] NEXT_ADDR_BASE = 8'h80;
   // Reset values of the cleared registers.
   localparam logic [7:0] EVENT_FLAGS_RST = 8'h00;
   localparam logic [7:0] EVENT_ENABLE_RST = 8'h00;
   // Event bit positions.
   localparam int EV_SECTOR_MARK = 0;
   localparam int EV_VECTOR_CRC = 1;
   localparam int EV_INPUT = 2;
   localparam int EV_STOPPED = 3;
   localparam int EV_BRANCH = 4;
   localparam int EV_XFER = 5;
   localparam int EV_OUTPUT = 6;
   localparam int EV_PARITY = 7;
   // Microword field positions.
   localparam int NA_LSB = 0;
   localparam int NA_MSB = 4;
   localparam int BR_LSB = 5;
   localparam int BR_MSB = 7;
   localparam int CTL_XFER_BIT = 0;
   localparam int CTL_OUTPUT_BIT = 2;
   localparam int CTL_STACK_BIT = 4;
   localparam int CTL_ALT_BIT = 7;
   localparam int CNT_PCRC_BIT = 6;
   // Address that stops the sequencer when fetched.
   localparam logic [4:0] STOP_ADDR = 5'h1F;
   // Branch command codes of the first table.
   localparam logic [2:0] BR_NEXT = 3'h0;
   localparam logic [2:0] BR_STOP_CRC = 3'h1;
   // Stack depth.
   localparam int STACK_DEPTH = 10;
endpackage

// File: hw/fmt_events.sv
// Formatter event flags, interrupt gating, ring stack and next-address pick.
// Assumes synchronous inputs and single-cycle strobes from the sequencer.
`timescale 1ns/1ps
module fmt_events
   import fmt_events_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic soft_reset,
   input wire logic [1:0] ctl_irq_enable,
   input wire logic edge_rising,
   input wire logic sector_mark_found_in,
   input wire logic seq_input,
   input wire logic vector_crc_error,
   input wire logic vector_parity_error,
   input wire logic seq_stopped,
   input wire logic word_end,
   input wire logic count_zero,
   input wire logic [7:0] word_next,
   input wire logic [7:0] word_control,
   input wire logic [7:0] word_count,
   input wire logic [7:0] word_data,
   input wire logic [7:0] branch_addr_reg,
   input wire logic use_data_target,
   input wire logic read_gate,
   input wire logic crc_error,
   input wire logic [7:0] push_data,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic disk_irq_n,
   output logic [4:0] fetch_addr,
   output logic fetch_valid,
   output logic seq_stop,
   output logic branch_hit
);

   // Elaboration check: the ring logic only serves depths from 2 to 16.
   // A deeper ring would need wider pointers than the four bits used here.
   if (DEPTH < 2 || DEPTH > 16) begin : g_depth_check
      $error("Stack depth out of range.");
   end

   // ****************************************************************
   // Decode and event detection
   // ****************************************************************

   // The soft reset acts exactly like the chip reset on these registers.
   wire clear_all = srst | soft_reset;
   wire wr_flags = wr && addr == EVENT_FLAGS_OFS;
   wire wr_enable = wr && addr == EVENT_ENABLE_OFS;
   wire rd_stack = rd && addr == RING_STACK_OFS;

   logic mark_reg;
   logic input_reg;
   logic stopped_reg;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic [7:0] enable_reg;
   logic [7:0] ev_set;

   // Edge picker shared by the two edge inputs whose polarity is selectable.
   function automatic logic pick_edge(input logic now, input logic was,
                                      input logic rising);
      pick_edge = rising ? (now & ~was) : (~now & was);
   endfunction

   // One set strobe per flag; a strobe only has to last one cycle.
   assign ev_set[EV_SECTOR_MARK] = pick_edge(sector_mark_found_in,
      mark_reg, edge_rising);
   assign ev_set[EV_VECTOR_CRC] = vector_crc_error;
   assign ev_set[EV_INPUT] = pick_edge(seq_input, input_reg,
      edge_rising);
   assign ev_set[EV_STOPPED] = seq_stopped & ~stopped_reg;
   assign ev_set[EV_BRANCH] = branch_hit;
   assign ev_set[EV_XFER] = word_end & word_control[CTL_XFER_BIT];
   assign ev_set[EV_OUTPUT] = word_end & word_control[CTL_OUTPUT_BIT];
   assign ev_set[EV_PARITY] = vector_parity_error;

   // A new event beats a write-one clear in the same cycle.
   // Giving the event priority means that a write-one clear never loses a status change.
   assign flags_next = (flags_reg & ~(wr_flags ? wdata : 8'h00))
      | ev_set;

   // ****************************************************************
   // Flag and enable registers
   // ****************************************************************

   // Edge history registers. They reset to the idle low level, so that no
   // false edge appears straight after reset.
   always_ff @(posedge clock) begin
      if (srst) begin
         mark_reg <= 1'b0;
         input_reg <= 1'b0;
         stopped_reg <= 1'b0;
      end else begin
         mark_reg <= sector_mark_found_in;
         input_reg <= seq_input;
         stopped_reg <= seq_stopped;
      end
   end

   // Flags and enables, both cleared by either reset.
   always_ff @(posedge clock) begin
      if (clear_all) begin
         flags_reg <= EVENT_FLAGS_RST;
         enable_reg <= EVENT_ENABLE_RST;
      end else begin
         flags_reg <= flags_next;
         if (wr_enable) begin
            enable_reg <= wdata;
         end
      end
   end

   // Interrupt level; both control enables must be set as well.
   // Registered so that the pin cannot glitch while flags and enables move.
   wire irq_any = |(flags_reg & enable_reg);
   wire irq_gate = &ctl_irq_enable;
   always_ff @(posedge clock) begin
      if (srst) begin
         disk_irq_n <= 1'b1;
      end else begin
         disk_irq_n <= ~(irq_any & irq_gate);
      end
   end

   // ****************************************************************
   // Ring stack
   // ****************************************************************

   // Storage is never reset; contents are undefined until pushed.
   // Pointers are four bits wide, which bounds the depth at sixteen.
   logic [7:0] stack_mem [DEPTH];
   logic [3:0] top_reg;
   logic [3:0] rd_ptr_reg;
   wire push = word_end & word_control[CTL_STACK_BIT];

   // Ring stepping helpers; both wrap at the configured depth.
   function automatic logic [3:0] ring_dec(input logic [3:0] p);
      ring_dec = (p == 4'h0) ? 4'(DEPTH - 1) : p - 4'h1;
   endfunction
   function automatic logic [3:0] ring_inc(input logic [3:0] p);
      ring_inc = (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
   endfunction

   // Only pointers reset; the data array deliberately has no reset.
   // A push writes one slot past the top; that slot then holds the newest.
   always_ff @(posedge clock) begin
      if (push) begin
         stack_mem[ring_inc(top_reg)] <= push_data;
      end
   end

   // Oldest entry is overwritten once ten are stored.
   always_ff @(posedge clock) begin
      if (srst) begin
         top_reg <= 4'h0;
         rd_ptr_reg <= 4'h0;
      end else if (push) begin
         top_reg <= ring_inc(top_reg);
         rd_ptr_reg <= ring_inc(top_reg);
      end else if (rd_stack) begin
         rd_ptr_reg <= ring_dec(rd_ptr_reg);
      end
   end

   // Read data mux, registered onto the port.
   // Unmapped addresses read as zero, so a stray read never shows stack data.
   logic [7:0] rdata_next;
   always_comb begin
      unique case (addr)
         EVENT_FLAGS_OFS: rdata_next = flags_reg;
         EVENT_ENABLE_OFS: rdata_next = enable_reg;
         RING_STACK_OFS: rdata_next = stack_mem[rd_ptr_reg];
         default: rdata_next = 8'h00;
      endcase
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         rdata <= rdata_next;
      end
   end

   // ****************************************************************
   // Next-address and branch selection
   // ****************************************************************

   // Command and address fields of the current microword.
   wire [2:0] br_cmd = word_next[BR_MSB:BR_LSB];
   // The first command table only applies with alternate select clear,
   // process-CRC set and the read gate open.
   wire first_table = ~word_control[CTL_ALT_BIT]
      & word_count[CNT_PCRC_BIT] & read_gate;
   wire stop_cond = first_table && br_cmd == BR_STOP_CRC
      && crc_error;
   wire [4:0] target = use_data_target ? word_data[4:0]
      : branch_addr_reg[4:0];
   wire [4:0] next_field = word_next[NA_MSB:NA_LSB];
   // Other command tables are not implemented; they take next address.
   wire [4:0] pick = next_field;
   wire do_fetch = word_end & count_zero;

   assign branch_hit = do_fetch & stop_cond;
   assign fetch_valid = do_fetch & ~stop_cond;
   assign fetch_addr = pick;
   // Fetching the stop address ends the program even when no branch fires.
   assign seq_stop = do_fetch & (stop_cond
      | (pick == STOP_ADDR));

   // Target is wired for later command tables only.
   wire unused_target = ^target;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   // Reset and write-one-to-clear behaviour of the flag register.
   reset_clears_a: assert property (soft_reset |=> flags_reg == 8'h00
      && enable_reg == 8'h00) else $error("Soft reset missed.");
   w1c_clears_a: assert property (wr_flags && wdata[0] && !ev_set[0]
      |=> !flags_reg[0]) else $error("Flag not cleared.");
   set_wins_a: assert property (wr_flags && ev_set[3] && !soft_reset
      |=> flags_reg[3]) else $error("Event lost.");

   // Each set strobe but the sector mark and input edges must leave its flag standing
   // one cycle later; a soft reset in the same cycle is the only thing allowed to beat it.
   crc_flag_a: assert property (vector_crc_error && !soft_reset
      |=> flags_reg[EV_VECTOR_CRC]) else $error("CRC flag lost.");
   stop_flag_a: assert property (seq_stopped && !stopped_reg
      && !soft_reset |=> flags_reg[EV_STOPPED])
      else $error("Stop flag lost.");
   branch_flag_a: assert property (branch_hit && !soft_reset
      |=> flags_reg[EV_BRANCH]) else $error("Branch flag lost.");
   xfer_flag_a: assert property (word_end && word_control[CTL_XFER_BIT]
      && !soft_reset |=> flags_reg[EV_XFER]) else $error("Transfer flag.");
   output_flag_a: assert property (word_end
      && word_control[CTL_OUTPUT_BIT] && !soft_reset
      |=> flags_reg[EV_OUTPUT]) else $error("Output flag lost.");
   parity_flag_a: assert property (vector_parity_error
      && !soft_reset |=> flags_reg[EV_PARITY])
      else $error("Parity flag lost.");

   // Interrupt level and its two gates.
   irq_level_a: assert property ((flags_reg & enable_reg) == 8'h00
      |=> disk_irq_n) else $error("Interrupt stuck.");
   irq_gate_a: assert property (|(flags_reg & enable_reg)
      && ctl_irq_enable == 2'b11 |=> !disk_irq_n)
      else $error("Interrupt missing.");
   gate_blocks_a: assert property (ctl_irq_enable != 2'b11
      |=> disk_irq_n) else $error("Gate left open.");

   // Fetch and stop selection.
   stop_addr_a: assert property (do_fetch && next_field == STOP_ADDR
      |-> seq_stop) else $error("No stop on 1F.");
   crc_stop_a: assert property (do_fetch && first_table
      && br_cmd == BR_STOP_CRC && crc_error |-> seq_stop && !fetch_valid)
      else $error("No CRC stop.");

   // Ring stack pointers.
   push_top_a: assert property (push |=> rd_ptr_reg == top_reg)
      else $error("Read not at newest.");
   read_rotate_a: assert property (rd_stack && !push
      |=> rd_ptr_reg == ring_dec($past(rd_ptr_reg)))
      else $error("Stack no rotate.");

   // Main scenarios that the bench is expected to reach.
   irq_c: cover property (!disk_irq_n);
   push_read_c: cover property (push ##1 rd_stack);
   stop_c: cover property (seq_stop);
   soft_clear_c: cover property (soft_reset && |flags_reg);
   ring_wrap_c: cover property (rd_stack && rd_ptr_reg == 4'h0);

endmodule // fmt_events

// File: test/mcu_model.sv
// Microcontroller model for the formatter register port.
// Assumes the bench clock; each strobe lasts exactly one cycle.
`timescale 1ns/1ps
module mcu_model (
   input wire logic clock,
   input wire logic [7:0] rdata,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd
);
   // The bus is idle from time zero.
   initial {addr, wdata, wr, rd} = 18'h00000;
   // Write cycle. Data is inverted once the strobe drops, so nothing leans
   // on a stale value.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock) #1 {addr, wdata, wr} = {a, d, 1'b1};
      @(posedge clock) #1 {wdata, wr} = {~d, 1'b0};
   endtask
   // Read cycle. Data is taken after the edge that sampled the strobe.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock) #1 {addr, rd} = {a, 1'b1};
      @(posedge clock) #1 rd = 1'b0;
      d = rdata;
   endtask
endmodule // mcu_model

// File: test/test_format_sequencer_events_branch.sv
// Bench for the formatter events block: flags, interrupt, stack, fetch.
// Assumes mcu_model drives the register port. The seed is fixed.
`timescale 1ns/1ps
module test_format_sequencer_events_branch;
   import fmt_events_pkg::*;
   logic clock, srst, soft_reset, edge_rising, sector_mark_found_in;
   logic seq_input, vector_crc_error, vector_parity_error, seq_stopped;
   logic word_end, count_zero, use_data_target, read_gate, crc_error;
   logic wr, rd, disk_irq_n, fetch_valid, seq_stop, branch_hit, stp, cs;
   logic [1:0] ctl_irq_enable;
   logic [4:0] fetch_addr, na;
   logic [7:0] word_next, word_control, word_count, word_data, ena, got;
   logic [7:0] branch_addr_reg, push_data, addr, wdata, rdata, q[$];
   int err_total, check_count, cycles, seed;
   fmt_events fmt_events_i (.clock(clock), .srst(srst),
      .soft_reset(soft_reset), .ctl_irq_enable(ctl_irq_enable),
      .edge_rising(edge_rising), .sector_mark_found_in(sector_mark_found_in),
      .seq_input(seq_input), .vector_crc_error(vector_crc_error),
      .vector_parity_error(vector_parity_error), .seq_stopped(seq_stopped),
      .word_end(word_end), .count_zero(count_zero), .word_next(word_next),
      .word_control(word_control), .word_count(word_count),
      .word_data(word_data), .branch_addr_reg(branch_addr_reg),
      .use_data_target(use_data_target), .read_gate(read_gate),
      .crc_error(crc_error), .push_data(push_data), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .disk_irq_n(disk_irq_n), .fetch_addr(fetch_addr),
      .fetch_valid(fetch_valid), .seq_stop(seq_stop),
      .branch_hit(branch_hit));
   mcu_model mcu_model_i (.clock(clock), .rdata(rdata), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd));
   // 40 MHz clock.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Step to just after the next rising edge.
   task automatic tick();
      @(posedge clock) #1;
   endtask
   // Byte compare; single bits are passed zero-extended.
   task automatic check(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Expected stop: the stop address is fetched, or code 001 meets a CRC
   // error while the first table applies.
   function automatic logic exp_stop(input logic [4:0] a,
      input logic [2:0] c, input logic e);
      exp_stop = (a == STOP_ADDR) || (c == BR_STOP_CRC && e);
   endfunction
   // Counts, then the verdict, then the end of the run.
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // A hung handshake must not stall the run.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      seed = 32'h8921;
      {srst, soft_reset, edge_rising, sector_mark_found_in} = 4'h8;
      {seq_input, vector_crc_error, vector_parity_error} = 3'h0;
      {seq_stopped, word_end, count_zero, use_data_target} = 4'h0;
      {read_gate, crc_error, ctl_irq_enable} = 4'hF;
      {word_next, word_control, word_data, branch_addr_reg} = 32'h0;
      {push_data, word_count} = 16'h0040;
      {err_total, check_count, cycles} = 96'h0;
      repeat (5) tick();
      srst = 1'b0;
      mcu_model_i.rd_reg(EVENT_FLAGS_OFS, got);
      check(got, EVENT_FLAGS_RST);
      mcu_model_i.rd_reg(EVENT_ENABLE_OFS, got);
      check(got, EVENT_ENABLE_RST);
      mcu_model_i.rd_reg(8'h10, got);
      check(got, 8'h00);
      $display("test reset done");
      // Each event alone. Bit 5 runs with its enable off, bits 6 and 7
      // with one control enable off, so both gates are seen blocking.
      for (int b = 0; b < 8; b++) begin
         edge_rising = 1'($random(seed));
         {sector_mark_found_in, seq_input} = {2{~edge_rising}};
         ctl_irq_enable = (b < 6) ? 2'h3 : 2'(b - 5);
         ena = (b == 5) ? ~(8'h01 << b) : 8'h01 << b;
         mcu_model_i.wr_reg(EVENT_FLAGS_OFS, 8'hFF);
         mcu_model_i.wr_reg(EVENT_ENABLE_OFS, ena);
         case (b)
            0: sector_mark_found_in = edge_rising;
            1: vector_crc_error = 1'b1;
            2: seq_input = edge_rising;
            3: seq_stopped = 1'b1;
            4: {word_next, word_end, count_zero} =
               {BR_STOP_CRC, 5'h05, 2'h3};
            5: {word_control, word_end} = 9'h003;
            6: {word_control, word_end} = 9'h009;
            default: vector_parity_error = 1'b1;
         endcase
         tick();
         {vector_crc_error, vector_parity_error, seq_stopped} = 3'h0;
         {word_next, word_control, word_end, count_zero} = 18'h0;
         mcu_model_i.rd_reg(EVENT_FLAGS_OFS, got);
         check(got, 8'h01 << b);
         check({7'h0, disk_irq_n}, {7'h0, !(b < 5 || b == 4)});
         mcu_model_i.wr_reg(EVENT_FLAGS_OFS, 8'h01 << b);
         mcu_model_i.rd_reg(EVENT_FLAGS_OFS, got);
         check(got, 8'h00);
         check({7'h0, disk_irq_n}, 8'h01);
      end
      // Corner: a write-one clear of bit 3 in the very cycle the stop rises.
      fork
         mcu_model_i.wr_reg(EVENT_FLAGS_OFS, 8'h08);
         begin
            tick();
            seq_stopped = 1'b1;
         end
      join
      seq_stopped = 1'b0;
      mcu_model_i.rd_reg(EVENT_FLAGS_OFS, got);
      check(got, 8'h08);
      $display("test events done");
      mcu_model_i.wr_reg(EVENT_ENABLE_OFS, 8'hFF);
      vector_parity_error = 1'b1;
      tick();
      {vector_parity_error, soft_reset} = 2'h1;
      tick();
      soft_reset = 1'b0;
      mcu_model_i.rd_reg(EVENT_FLAGS_OFS, got);
      check(got, 8'h00);
      mcu_model_i.rd_reg(EVENT_ENABLE_OFS, got);
      check(got, 8'h00);
      $display("test soft reset done");
      // Twelve pushes overrun the ten-deep ring; eleven reads wrap once.
      {word_control, word_end} = 9'h021;
      for (int i = 0; i < 12; i++) begin
         push_data = 8'($random(seed));
         q.push_back(push_data);
         tick();
      end
      {word_control, word_end} = 9'h000;
      for (int i = 0; i < 11; i++) begin
         mcu_model_i.rd_reg(RING_STACK_OFS, got);
         check(got, q[11 - i % 10]);
      end
      $display("test stack done");
      // Word ends with the count at zero; odd passes use the CRC stop code.
      {count_zero, word_end} = 2'h3;
      for (int i = 0; i < 16; i++) begin
         na = (i == 0) ? STOP_ADDR : 5'($random(seed));
         crc_error = 1'($random(seed));
         word_next = {(i % 2) ? BR_STOP_CRC : BR_NEXT, na};
         {word_data, branch_addr_reg} = 16'($random(seed));
         stp = exp_stop(na, word_next[BR_MSB:BR_LSB], crc_error);
         cs = i % 2 == 1 && crc_error;
         #1;
         check({7'h0, seq_stop}, {7'h0, stp});
         check({7'h0, branch_hit}, {7'h0, cs});
         check({7'h0, fetch_valid}, {7'h0, !cs});
         if (!stp)
            check({3'h0, fetch_addr}, {3'h0, na});
         tick();
      end
      // Stop address and CRC stop code, but no word end: nothing happens.
      {count_zero, word_end, crc_error} = 3'h5;
      word_next = {BR_STOP_CRC, STOP_ADDR};
      #1;
      check({7'h0, seq_stop}, 8'h00);
      check({7'h0, fetch_valid}, 8'h00);
      check({7'h0, branch_hit}, 8'h00);
      {count_zero, word_end} = 2'h0;
      $display("test fetch done");
      end_sim();
   end
endmodule // test_format_sequencer_events_branch
